// File: rtl/nvm_pkg.sv
// constants for the on-chip nonvolatile data store access controller
// assumes a core-side i/o register port and one 100 MHz clock
//
// Contract
// [RULE_01] a write in progress runs on through deep sleep and completes
// [RULE_02] write timing clock stays requested after a write done in sleep
// [RULE_03] system reset during a write does not abort it
// [RULE_04] address bits 15:9 and control bits 7:4 read as zero
// [RULE_05] array is byte addressed by a 9-bit linear address, 0 to 511
// [RULE_06] address undefined after reset; software loads it before access
// [RULE_07] data register supplies write byte and receives read byte
// [RULE_08] bit 3 with global flag gives a level irq while strobe clear
// [RULE_09] write strobe starts write only within four cycles of master enable
// [RULE_10] master write enable self-clears four cycles after being set
// [RULE_11] software sets address, data, master enable, then write strobe
// [RULE_12] read strobe loads data register at current address at once
// [RULE_13] a read stalls the core for four cycles
// [RULE_14] registers at i/o 0x00-0x3f, or plus 0x20 in data space
// [RULE_15] bit set/clear up to 0x1f touches only the addressed bit
// [RULE_16] write strobe stays set during a write, hardware clears it
// [RULE_17] write lasts 27072 cycles of the calibrated rc oscillator
// [RULE_18] during a write reads are ignored and address is frozen
// [RULE_19] a write start stalls the core for two cycles
// [RULE_20] a write strobe during an ongoing write is ignored
package nvm_pkg;
	localparam logic [5:0] ADDR_CONTROL  = 6'h1f;
	localparam logic [5:0] ADDR_DATA     = 6'h20;
	localparam logic [5:0] ADDR_ADDR_LOW = 6'h21;
	localparam logic [5:0] ADDR_ADDR_HI  = 6'h22;
	localparam logic [6:0] DATA_SPACE_OFS = 7'h20;
	localparam logic [5:0] BIT_ACCESS_MAX = 6'h1f;
	localparam int CTL_READ   = 0;
	localparam int CTL_WRITE  = 1;
	localparam int CTL_MWE    = 2;
	localparam int CTL_IRQ_EN = 3;
	localparam int NVM_DEPTH  = 512;
	localparam int NVM_AW     = 9;
	localparam int MWE_WINDOW_CYC = 4;
	localparam int READ_STALL_CYC = 4;
	localparam int WRITE_STALL_CYC = 2;
	localparam int RC_WRITE_CYC = 27072;
	localparam logic [2:0] MWE_CNT_W = 3'(MWE_WINDOW_CYC);
	localparam logic [2:0] RD_STALL_W = 3'(READ_STALL_CYC);
	localparam logic [2:0] WR_STALL_W = 3'(WRITE_STALL_CYC);
	typedef enum logic [1:0] {ST_IDLE, ST_WRITING} wr_state_t;
endpackage : nvm_pkg

// File: rtl/nvm_array.sv
// byte array of the nonvolatile store, registered read data
// assumes single port use: never read and written in one cycle
`timescale 1ns/1ps
module nvm_array
	import nvm_pkg::*;
(
	// clock
	input  wire logic              clk,
	// access
	input  wire logic              i_we,
	input  wire logic              i_re,
	input  wire logic [NVM_AW-1:0] i_addr,
	input  wire logic [7:0]        i_wdata,
	output logic      [7:0]        o_rdata
);
	logic [7:0] mem [NVM_DEPTH];

	always_ff @(posedge clk) begin
		if (i_we) begin
			mem[i_addr] <= i_wdata; // [RULE_05]
		end
		if (i_re) begin
			o_rdata <= mem[i_addr];
		end
	end
endmodule : nvm_array

// File: rtl/nvm_ctrl.sv
// access controller: i/o registers, write timing, core stall
// assumes the core holds its i/o strobes one cycle and obeys stall
`timescale 1ns/1ps
module nvm_ctrl
	import nvm_pkg::*;
(
	// clocks and resets
	input  wire logic       I_REF_CLK,
	input  wire logic       I_RST_N,
	input  wire logic       I_RC_TICK,
	input  wire logic       I_SYS_RST,
	// core i/o port
	input  wire logic [6:0] I_IO_ADDR,
	input  wire logic       I_IO_DSPACE,
	input  wire logic       I_IO_WR,
	input  wire logic       I_IO_RD,
	input  wire logic       I_IO_BITOP,
	input  wire logic       I_IO_BITVAL,
	input  wire logic [2:0] I_IO_BITSEL,
	input  wire logic [7:0] I_IO_WDATA,
	output logic      [7:0] O_IO_RDATA,
	output logic            O_IO_HIT,
	// core status
	input  wire logic       I_GLOBAL_IRQ_EN,
	input  wire logic       I_DEEP_SLEEP,
	output logic            O_CPU_STALL,
	output logic            O_READY_IRQ,
	output logic            O_WRITE_CLK_REQ
);
	logic [5:0]        io_addr;
	logic              addr_ok;
	logic              sel_ctl;
	logic              sel_dat;
	logic              sel_alo;
	logic              sel_ahi;
	logic              wr_any;
	logic [7:0]        wval;
	logic [7:0]        ctl_view;
	logic [NVM_AW-1:0] nvm_address_reg;
	logic [7:0]        nvm_data_reg;
	logic              irq_en_reg;
	logic              mwe_reg;
	logic [2:0]        mwe_cnt_reg;
	logic [2:0]        stall_reg;
	logic [14:0]       rc_cnt_reg;
	logic              rd_pend_reg;
	logic              writing;
	logic              wr_start;
	logic              rd_start;
	logic              mwe_set;
	logic [7:0]        arr_rdata;
	wr_state_t         state_reg;

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	always_comb begin
		io_addr = I_IO_ADDR[5:0];
		addr_ok = 1'b0;
		if (I_IO_DSPACE) begin
			io_addr = 6'(I_IO_ADDR - DATA_SPACE_OFS); // [RULE_14]
			// top of the 7-bit range would wrap onto low i/o slots
			addr_ok = I_IO_ADDR >= DATA_SPACE_OFS
				&& !(I_IO_ADDR[6] && I_IO_ADDR[5]);
		end else begin
			addr_ok = ~I_IO_ADDR[6];
		end
	end
	assign sel_ctl = addr_ok && io_addr == ADDR_CONTROL;
	assign sel_dat = addr_ok && io_addr == ADDR_DATA;
	assign sel_alo = addr_ok && io_addr == ADDR_ADDR_LOW;
	assign sel_ahi = addr_ok && io_addr == ADDR_ADDR_HI;
	assign O_IO_HIT = sel_ctl | sel_dat | sel_alo | sel_ahi;
	assign writing = state_reg == ST_WRITING;
	assign ctl_view = {4'h0, irq_en_reg, mwe_reg, writing, 1'b0}; // [RULE_04]

	// bit ops only reach the low window, and change one bit alone
	always_comb begin
		wval = I_IO_WDATA;
		wr_any = I_IO_WR;
		if (I_IO_BITOP) begin
			wval = ctl_view;
			wval[I_IO_BITSEL] = I_IO_BITVAL; // [RULE_15]
			wr_any = sel_ctl && io_addr <= BIT_ACCESS_MAX;
		end
	end

	// strobe set with a live master enable, not already writing
	// a bit op carries the rest of the view: only its own bit counts
	assign mwe_set = wr_any && sel_ctl && wval[CTL_MWE]
		&& !(I_IO_BITOP && I_IO_BITSEL != 3'(CTL_MWE)); // [RULE_15]
	assign wr_start = wr_any && sel_ctl && wval[CTL_WRITE] && mwe_reg
		&& !writing
		&& (I_IO_BITOP || !wval[CTL_MWE]); // [RULE_09] [RULE_20]
	assign rd_start = wr_any && sel_ctl && wval[CTL_READ]
		&& !writing; // [RULE_18]

	// ----------------------------------------
	// control bits
	// ----------------------------------------
	always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			irq_en_reg <= 1'b0;
		end else if (I_SYS_RST) begin
			irq_en_reg <= 1'b0;
		end else if (wr_any && sel_ctl) begin
			irq_en_reg <= wval[CTL_IRQ_EN];
		end
	end

	always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			mwe_reg     <= 1'b0;
			mwe_cnt_reg <= 3'h0;
		end else if (I_SYS_RST) begin
			mwe_reg     <= 1'b0;
			mwe_cnt_reg <= 3'h0;
		end else if (mwe_set) begin
			mwe_reg     <= 1'b1;
			mwe_cnt_reg <= MWE_CNT_W;
		end else if (mwe_cnt_reg != 3'h0) begin
			mwe_cnt_reg <= mwe_cnt_reg - 3'h1;
			mwe_reg     <= mwe_cnt_reg != 3'h1; // [RULE_10]
		end else begin
			mwe_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// address and data registers
	// ----------------------------------------
	// address has no reset: software must load it first
	always_ff @(posedge I_REF_CLK) begin
		if (wr_any && sel_alo && !writing) begin
			nvm_address_reg[7:0] <= wval; // [RULE_06] [RULE_18]
		end
		if (wr_any && sel_ahi && !writing) begin
			nvm_address_reg[8] <= wval[0];
		end
	end

	always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			nvm_data_reg <= 8'h00;
		end else if (rd_pend_reg) begin
			nvm_data_reg <= arr_rdata; // [RULE_07] [RULE_12]
		end else if (wr_any && sel_dat) begin
			nvm_data_reg <= wval;
		end
	end

	always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			rd_pend_reg <= 1'b0;
		end else begin
			rd_pend_reg <= rd_start;
		end
	end

	// ----------------------------------------
	// write timer
	// ----------------------------------------
	// system reset and sleep never reach this: only I_RST_N ends a write early
	always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			state_reg  <= ST_IDLE;
			rc_cnt_reg <= 15'h0000;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (wr_start) begin
						state_reg  <= ST_WRITING;
						rc_cnt_reg <= 15'(RC_WRITE_CYC - 1); // [RULE_17]
					end
				end
				ST_WRITING: begin
					if (I_RC_TICK) begin
						if (rc_cnt_reg == 15'h0000) begin
							state_reg <= ST_IDLE; // [RULE_16]
						end else begin
							rc_cnt_reg <= rc_cnt_reg - 15'h0001;
						end
					end
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end // [RULE_01] [RULE_03]

	// rc clock kept requested after a sleep write: costs sleep current
	always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_WRITE_CLK_REQ <= 1'b0;
		end else if (wr_start) begin
			O_WRITE_CLK_REQ <= 1'b1;
		end else if (!writing && !I_DEEP_SLEEP) begin
			O_WRITE_CLK_REQ <= 1'b0; // [RULE_02]
		end
	end

	// ----------------------------------------
	// core stall
	// ----------------------------------------
	always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			stall_reg <= 3'h0;
		end else if (rd_start) begin
			stall_reg <= RD_STALL_W; // [RULE_13]
		end else if (wr_start) begin
			stall_reg <= WR_STALL_W; // [RULE_19]
		end else if (stall_reg != 3'h0) begin
			stall_reg <= stall_reg - 3'h1;
		end
	end
	assign O_CPU_STALL = stall_reg != 3'h0;

	// level request, held for as long as no write runs
	assign O_READY_IRQ = irq_en_reg && I_GLOBAL_IRQ_EN && !writing; // [RULE_08]

	// ----------------------------------------
	// read mux and array
	// ----------------------------------------
	always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_IO_RDATA <= 8'h00;
		end else if (I_IO_RD) begin
			O_IO_RDATA <= sel_ctl ? ctl_view :
				sel_dat ? nvm_data_reg :
				sel_alo ? nvm_address_reg[7:0] :
				sel_ahi ? {7'h00, nvm_address_reg[8]} : 8'h00; // [RULE_04]
		end
	end

	nvm_array u_array (
		.clk     (I_REF_CLK),
		.i_we    (wr_start),
		.i_re    (rd_start),
		.i_addr  (nvm_address_reg),
		.i_wdata (nvm_data_reg),
		.o_rdata (arr_rdata)
	);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (!I_RST_N);

	AST_MWE_CLEARS: assert property ( // [RULE_10]
		$rose(mwe_reg) |-> ##4 !mwe_reg)
		else $error("master enable not cleared after four cycles");
	AST_WR_NEEDS_MWE: assert property (wr_start |-> mwe_reg) // [RULE_09]
		else $error("write started without master enable");
	AST_RD_STALL: assert property ( // [RULE_13]
		rd_start |=> O_CPU_STALL [*4] ##1 !O_CPU_STALL)
		else $error("read stall not four cycles");
	AST_WR_STALL: assert property ( // [RULE_19]
		wr_start |=> O_CPU_STALL [*2] ##1 !O_CPU_STALL)
		else $error("write stall not two cycles");
	AST_NO_RD_IN_WR: assert property (writing |-> !rd_start) // [RULE_18]
		else $error("read taken during write");
	AST_ADDR_FROZEN: assert property ( // [RULE_18]
		writing && $past(writing) |-> $stable(nvm_address_reg))
		else $error("address changed during write");
	AST_IRQ_LEVEL: assert property ( // [RULE_08]
		O_READY_IRQ |-> !writing && irq_en_reg)
		else $error("ready irq while writing");
	AST_RD_DATA: assert property ( // [RULE_12]
		rd_start |=> ##1 nvm_data_reg == $past(arr_rdata))
		else $error("read data not loaded");
	AST_WR_HOLD: assert property (wr_start |=> writing [*8]) // [RULE_16]
		else $error("write ended early");
	AST_SYSRST_KEEPS: assert property ( // [RULE_03]
		writing && I_SYS_RST && rc_cnt_reg != 15'h0000 |=> writing)
		else $error("system reset aborted write");
	AST_RSVD_ZERO: assert property (ctl_view[7:4] == 4'h0) // [RULE_04]
		else $error("reserved control bits nonzero");

	COV_WRITE: cover property (wr_start);
	COV_READ: cover property (rd_start);
	COV_WR_DONE: cover property ($fell(writing));
	COV_IGNORED: cover property (writing && wr_any && sel_ctl && wval[CTL_WRITE]);
endmodule : nvm_ctrl

// File: dv/nvm_core_model.sv
// core model: issues i/o register writes, reads and bit operations
// assumes it is called 1 ns after a rising clock edge
`timescale 1ns/1ps
module nvm_core_model (
	// clock
	input  wire logic       clk,
	// controller side
	input  wire logic       i_stall,
	input  wire logic [7:0] i_rdata,
	output logic      [6:0] o_addr,
	output logic            o_dspace,
	output logic            o_wr,
	output logic            o_rd,
	output logic            o_bitop,
	output logic            o_bitval,
	output logic      [2:0] o_bitsel,
	output logic      [7:0] o_wdata
);
	logic hung = 1'b0;
	int   stalls;
	initial begin
		{o_addr, o_dspace, o_wr, o_rd, o_bitop} = '0;
		{o_bitval, o_bitsel, o_wdata} = '0;
	end
	// ----------------------------------------------------------------
	// one request: k 0 write, 1 read, 2 bit op (d[3] value, d[2:0] bit)
	// ----------------------------------------------------------------
	task automatic op(input logic [6:0] a, input logic ds,
		input logic [1:0] k, input logic [7:0] d, output logic [7:0] q);
		o_addr = a;
		o_dspace = ds;
		o_wdata = d;
		o_wr = (k == 2'h0);
		o_rd = (k == 2'h1);
		o_bitop = (k == 2'h2);
		o_bitval = d[3];
		o_bitsel = d[2:0];
		@(posedge clk);
		#1;
		q = i_rdata;
		{o_wr, o_rd, o_bitop} = '0;
		// released address and data lines never keep the last value
		o_addr = ~a;
		o_wdata = ~d;
		stalls = 0;
		// stall rises at the request edge; count the edges it holds
		while (i_stall && stalls < 20) begin
			@(posedge clk);
			#1;
			stalls++;
		end
		if (stalls == 20) hung = 1'b1;
		// one idle edge keeps the strobes of two calls apart
		if (stalls == 0) begin
			@(posedge clk);
			#1;
		end
	endtask : op
endmodule : nvm_core_model

// File: dv/tb.sv
// testbench: core model drives the controller, integer model checks it
// assumes one 100 MHz clock and an rc tick on every cycle
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
	errors++; \
	$display("Error at %0t: got %h expected %h", $time, g, e); \
	end end
module tb;
	import nvm_pkg::*;
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       rc_tick = 1'b1;
	logic       sys_rst = 1'b0;
	logic       gie = 1'b1;
	logic       sleep = 1'b0;
	logic       stall, irq, clk_req, ds, wr, rd, bop, bval, hit;
	logic [1:0] k;
	logic [6:0] addr;
	logic [2:0] bsel;
	logic [7:0] wdata, rdata, q;
	int         errors = 0;
	int         comparisons = 0;
	int         seed = 32'hf66c;
	int         mem [int];
	int         t0;
	logic [8:0] a;
	logic [7:0] d;
	always #5 clk = ~clk;
	nvm_ctrl u_dut (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_RC_TICK(rc_tick),
		.I_SYS_RST(sys_rst), .I_IO_ADDR(addr), .I_IO_DSPACE(ds),
		.I_IO_WR(wr), .I_IO_RD(rd), .I_IO_BITOP(bop), .I_IO_BITVAL(bval),
		.I_IO_BITSEL(bsel), .I_IO_WDATA(wdata), .O_IO_RDATA(rdata),
		.O_IO_HIT(hit), .I_GLOBAL_IRQ_EN(gie), .I_DEEP_SLEEP(sleep),
		.O_CPU_STALL(stall), .O_READY_IRQ(irq), .O_WRITE_CLK_REQ(clk_req));
	nvm_core_model u_core (.clk(clk), .i_stall(stall), .i_rdata(rdata),
		.o_addr(addr), .o_dspace(ds), .o_wr(wr), .o_rd(rd), .o_bitop(bop),
		.o_bitval(bval), .o_bitsel(bsel), .o_wdata(wdata));
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic w(input logic [5:0] ad, input logic [7:0] dt);
		u_core.op({1'b0, ad}, 1'b0, 2'h0, dt, q);
	endtask : w
	task automatic r(input logic [5:0] ad, input logic [7:0] e);
		u_core.op({1'b0, ad}, 1'b0, 2'h1, 8'h00, q);
		`CHK(q, e)
	endtask : r
	task automatic stop_test;
		`CHK(u_core.hung, 1'b0)
		if (errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : stop_test
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge clk);
		#1;
		rst_n = 1'b1;
		`CHK(hit, 1'b0)
		r(ADDR_CONTROL, 8'h00);
		r(6'h10, 8'h00);
		w(ADDR_ADDR_HI, 8'hff);
		r(ADDR_ADDR_HI, 8'h01);
		u_core.op({1'b0, ADDR_CONTROL}, 1'b0, 2'h2, 8'h0b, q);
		r(ADDR_CONTROL, 8'h08);
		`CHK(irq, 1'b1)
		gie = 1'b0;
		#1 `CHK(irq, 1'b0)
		@(posedge clk);
		#1;
		gie = 1'b1;
		w(ADDR_CONTROL, 8'h0a);
		r(ADDR_CONTROL, 8'h08);
		w(ADDR_CONTROL, 8'h0c);
		repeat (5) @(posedge clk);
		#1;
		r(ADDR_CONTROL, 8'h08);
		w(ADDR_CONTROL, 8'h0a);
		r(ADDR_CONTROL, 8'h08);
		for (int i = 0; i < 2; i++) begin
			a = 9'($random(seed));
			d = 8'($random(seed));
			// address, data, master enable, then strobe
			w(ADDR_ADDR_LOW, a[7:0]);
			w(ADDR_ADDR_HI, {7'h00, a[8]});
			u_core.op(7'(ADDR_DATA) + DATA_SPACE_OFS, 1'b1, 2'h0, d,
				q);
			// released 0x3f in data space lands on control
			`CHK(hit, 1'b1)
			// second pass uses single-bit sets, as a bit op core would
			k = (i == 1) ? 2'h2 : 2'h0;
			u_core.op({1'b0, ADDR_CONTROL}, 1'b0, k,
				(i == 1) ? 8'h0a : 8'h0c, q);
			t0 = $time;
			u_core.op({1'b0, ADDR_CONTROL}, 1'b0, k,
				(i == 1) ? 8'h09 : 8'h0a, q);
			`CHK(u_core.stalls, WRITE_STALL_CYC)
			mem[a] = d;
			`CHK(irq, 1'b0)
			r(ADDR_CONTROL, 8'h0a);
			if (i == 0) begin
				sleep = 1'b1;
				sys_rst = 1'b1;
				@(posedge clk);
				#1;
				sys_rst = 1'b0;
				w(ADDR_ADDR_LOW, ~a[7:0]);
				w(ADDR_CONTROL, 8'h01);
				w(ADDR_CONTROL, 8'h0c);
				w(ADDR_CONTROL, 8'h0a);
				r(ADDR_ADDR_LOW, a[7:0]);
				r(ADDR_DATA, d);
			end
			while (irq !== 1'b1 && ($time - t0) < 300000) begin
				@(posedge clk);
				#1;
			end
			if (irq !== 1'b1) begin
				errors++;
				stop_test();
			end
			t0 = int'(($time - t0) / 10);
			`CHK(t0 - RC_WRITE_CYC inside {[0:8]}, 1'b1)
			if (i == 0) begin
				`CHK(clk_req, 1'b1)
				sleep = 1'b0;
				repeat (2) @(posedge clk);
				#1 `CHK(clk_req, 1'b0)
			end
			w(ADDR_DATA, ~d);
			w(ADDR_CONTROL, 8'h09);
			`CHK(u_core.stalls, READ_STALL_CYC)
			r(ADDR_DATA, 8'(mem[a]));
		end
		stop_test();
	end
endmodule : tb
